/* hdl/free_running_watchdog.v */
// free_running_watchdog.v: free-running watchdog unit with key-sequence clear
// assumes a byte-wide register bus synchronous to clk_sys, and a low-speed clock
// level sampled as an ordinary synchronous input
`timescale 1ns/1ps
`include "watchdog_defs.vh"

// Contract
// - the counter starts by itself after reset and nothing software writes stops it.
// - an overflow without a clear raises the non-maskable watchdog request.
// - a second overflow without a clear between raises the watchdog reset.
// - reading the clear-key register returns the key phase pointer in bit 0.
// - the pointer goes to zero on reset and on every overflow.
// - every enabled write to the clear-key register toggles the pointer, unless an overflow comes in the same cycle.
// - writing 5AH at pointer zero then 0A5H at pointer one clears the counter.
// - clear-key writes are ignored after reset or stop exit until the low-speed clock runs.
// - period codes 00, 01, 10, 11 give 125 ms, 500 ms, 2 s and 8 s on the small variant.
// - the large variant gives 131 ms, 524 ms, 2.1 s and 8.4 s, and the field resets to 10.
// - the clear-key register resets to 00H and the mode register to 02H, both 8 bits.
// - a wrong key does not clear the counter but still toggles the pointer.
// - the counter halts in stop mode, runs in halt mode, and its request wakes from halt.
module free_running_watchdog #(
   parameter LARGE_VARIANT = 0,
   parameter LS_HZ = `LOW_SPEED_CLOCK_HZ
) (
   input wire clk_sys,
   input wire rst_n,
   input wire lowSpeedClock,
   input wire lowSpeedClockRunning,
   input wire stopMode,
   input wire [15:0] sfrAddr,
   input wire sfrWrite,
   input wire sfrRead,
   input wire [7:0] sfrWrData,
   output reg [7:0] sfrRdData,
   output reg watchdogNmiRequest,
   output reg haltWake,
   output reg watchdogReset
);

   // ----------------------------------------------------------------------
   // overflow periods in low-speed ticks
   // ----------------------------------------------------------------------
   // small and large variant periods
   localparam integer TICKS0_SMALL = (`PERIOD0_SMALL_MS * LS_HZ) / 1000;
   localparam integer TICKS1_SMALL = (`PERIOD1_SMALL_MS * LS_HZ) / 1000;
   localparam integer TICKS2_SMALL = (`PERIOD2_SMALL_MS * LS_HZ) / 1000;
   localparam integer TICKS3_SMALL = (`PERIOD3_SMALL_MS * LS_HZ) / 1000;
   localparam integer TICKS0_LARGE = (`PERIOD0_LARGE_MS * LS_HZ) / 1000;
   localparam integer TICKS1_LARGE = (`PERIOD1_LARGE_MS * LS_HZ) / 1000;
   localparam integer TICKS2_LARGE = (`PERIOD2_LARGE_MS * LS_HZ) / 1000;
   localparam integer TICKS3_LARGE = (`PERIOD3_LARGE_MS * LS_HZ) / 1000;

   // whole ticks only, so a period that is not a tick multiple rounds down
   localparam integer TICKS0 = (LARGE_VARIANT != 0) ? TICKS0_LARGE : TICKS0_SMALL;
   localparam integer TICKS1 = (LARGE_VARIANT != 0) ? TICKS1_LARGE : TICKS1_SMALL;
   localparam integer TICKS2 = (LARGE_VARIANT != 0) ? TICKS2_LARGE : TICKS2_SMALL;
   localparam integer TICKS3 = (LARGE_VARIANT != 0) ? TICKS3_LARGE : TICKS3_SMALL;

   // cut to the timer's 20-bit limit width on purpose
   localparam [19:0] LIMIT0 = TICKS0[19:0];
   localparam [19:0] LIMIT1 = TICKS1[19:0];
   localparam [19:0] LIMIT2 = TICKS2[19:0];
   localparam [19:0] LIMIT3 = TICKS3[19:0];

   reg lsPrev_reg;
   reg writeEnable_reg;
   reg writeEnable_next;
   reg keyPhasePointer_reg;
   reg keyPhasePointer_next;
   reg firstKeyOk_reg;
   reg firstKeyOk_next;
   reg firstOverflow_reg;
   reg firstOverflow_next;
   reg [7:0] periodSelect_reg;
   reg [7:0] periodSelect_next;
   reg [7:0] rdData_next;
   reg nmiPulse_next;
   reg resetPulse_next;
   wire tick;
   wire overflow;
   wire hitClearKey;
   wire hitPeriodSelect;
   wire keyIsFirst;
   wire keyIsSecond;
   wire keyWrite;
   wire modeWrite;
   wire counterClear;

   // ----------------------------------------------------------------------
   // address and key decode
   // ----------------------------------------------------------------------
   assign hitClearKey = (sfrAddr == `ADDR_CLEAR_KEY);
   assign hitPeriodSelect = (sfrAddr == `ADDR_PERIOD_SELECT);
   assign keyIsFirst = (sfrWrData == `KEY_FIRST);
   assign keyIsSecond = (sfrWrData == `KEY_SECOND);

   // no ticks in stop mode, halt mode does not gate
   // edge history resets low, the idle level of the slow clock, so no false tick
   assign tick = lowSpeedClock && !lsPrev_reg && !stopMode;
   // clear-key writes only once the low-speed clock runs, mode writes at any time
   assign keyWrite = sfrWrite && hitClearKey && writeEnable_reg;
   assign modeWrite = sfrWrite && hitPeriodSelect;
   // second key at pointer one after an accepted first key
   // any other value leaves the counter alone
   assign counterClear = keyWrite && keyPhasePointer_reg && firstKeyOk_reg && keyIsSecond;

   // ----------------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------------
   // runs from reset with no stop control
   watchdog_period_timer #(
      .CNT_W(20),
      .LIMIT0(LIMIT0),
      .LIMIT1(LIMIT1),
      .LIMIT2(LIMIT2),
      .LIMIT3(LIMIT3)
   ) timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(tick),
      .clear(counterClear),
      .periodSel(periodSelect_reg[`PERIOD_SELECT_HI:`PERIOD_SELECT_LO]),
      .overflow(overflow)
   );

   // ----------------------------------------------------------------------
   // slow clock edge detect
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lsPrev_reg <= 1'b0;
      end
      else
      begin
         lsPrev_reg <= lowSpeedClock;
      end
   end

   // ----------------------------------------------------------------------
   // write gating
   // ----------------------------------------------------------------------
   always @*
   begin
      writeEnable_next = writeEnable_reg;
      // stop mode drops the enable until the oscillator is back
      if (stopMode)
      begin
         writeEnable_next = 1'b0;
      end
      else if (lowSpeedClockRunning)
      begin
         writeEnable_next = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         writeEnable_reg <= 1'b0;
      end
      else
      begin
         writeEnable_reg <= writeEnable_next;
      end
   end

   // ----------------------------------------------------------------------
   // key sequence
   // ----------------------------------------------------------------------
   always @*
   begin
      keyPhasePointer_next = keyPhasePointer_reg;
      firstKeyOk_next = firstKeyOk_reg;
      // overflow wins over a write in the same cycle
      if (overflow)
      begin
         keyPhasePointer_next = 1'b0;
         firstKeyOk_next = 1'b0;
      end
      else if (keyWrite)
      begin
         keyPhasePointer_next = ~keyPhasePointer_reg;
         // only a first key at pointer zero arms the second step
         firstKeyOk_next = !keyPhasePointer_reg && keyIsFirst;
      end
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         keyPhasePointer_reg <= 1'b0;
         firstKeyOk_reg <= 1'b0;
      end
      else
      begin
         keyPhasePointer_reg <= keyPhasePointer_next;
         firstKeyOk_reg <= firstKeyOk_next;
      end
   end

   // ----------------------------------------------------------------------
   // mode register
   // ----------------------------------------------------------------------
   always @*
   begin
      periodSelect_next = periodSelect_reg;
      // upper bits are kept storable, only bits 1-0 steer the period
      if (modeWrite)
      begin
         periodSelect_next = sfrWrData;
      end
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         periodSelect_reg <= `RESET_PERIOD_SELECT;
      end
      else
      begin
         periodSelect_reg <= periodSelect_next;
      end
   end

   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   // pointer in bit 0, idle and unmapped reads give zero
   always @*
   begin
      rdData_next = 8'h00;
      if (sfrRead && hitClearKey)
      begin
         rdData_next = {7'h00, keyPhasePointer_reg};
      end
      else if (sfrRead && hitPeriodSelect)
      begin
         rdData_next = periodSelect_reg;
      end
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sfrRdData <= 8'h00;
      end
      else
      begin
         sfrRdData <= rdData_next;
      end
   end

   // ----------------------------------------------------------------------
   // interrupt and reset
   // ----------------------------------------------------------------------
   always @*
   begin
      firstOverflow_next = firstOverflow_reg;
      nmiPulse_next = 1'b0;
      resetPulse_next = 1'b0;
      if (overflow && firstOverflow_reg)
      begin
         resetPulse_next = 1'b1;
         firstOverflow_next = 1'b0;
      end
      else if (overflow)
      begin
         // the same event releases halt mode
         nmiPulse_next = 1'b1;
         firstOverflow_next = 1'b1;
      end
      else if (counterClear)
      begin
         firstOverflow_next = 1'b0;
      end
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         firstOverflow_reg <= 1'b0;
      end
      else
      begin
         firstOverflow_reg <= firstOverflow_next;
      end
   end

   // one-cycle pulses, all straight from flip-flops
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         watchdogNmiRequest <= 1'b0;
         haltWake <= 1'b0;
         watchdogReset <= 1'b0;
      end
      else
      begin
         watchdogNmiRequest <= nmiPulse_next;
         haltWake <= nmiPulse_next;
         watchdogReset <= resetPulse_next;
      end
   end

endmodule // free_running_watchdog

/* shared/watchdog_defs.vh */
// watchdog_defs.vh: addresses, field positions, reset values and periods of the watchdog unit
// assumes a byte-wide special-function-register bus with 16-bit addresses
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define ADDR_CLEAR_KEY 16'hf00e
`define ADDR_PERIOD_SELECT 16'hf00f

// ----------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------
`define RESET_CLEAR_KEY 8'h00
`define RESET_PERIOD_SELECT 8'h02
`define PERIOD_SELECT_LO 0
`define PERIOD_SELECT_HI 1
`define KEY_PHASE_POINTER_BIT 0

// ----------------------------------------------------------------------
// clear keys
// ----------------------------------------------------------------------
`define KEY_FIRST 8'h5a
`define KEY_SECOND 8'ha5

// ----------------------------------------------------------------------
// low-speed clock rate and overflow periods in milliseconds
// ----------------------------------------------------------------------
`define LOW_SPEED_CLOCK_HZ 32768
`define PERIOD0_SMALL_MS 125
`define PERIOD1_SMALL_MS 500
`define PERIOD2_SMALL_MS 2000
`define PERIOD3_SMALL_MS 8000
`define PERIOD0_LARGE_MS 131
`define PERIOD1_LARGE_MS 524
`define PERIOD2_LARGE_MS 2100
`define PERIOD3_LARGE_MS 8400

`endif

/* hdl/watchdog_period_timer.v */
// watchdog_period_timer.v: counter of low-speed clock ticks with a selectable overflow limit
// assumes tick is a one-cycle pulse per rising low-speed clock edge, already gated by stop mode
`timescale 1ns/1ps

module watchdog_period_timer #(
   parameter CNT_W = 20,
   parameter [19:0] LIMIT0 = 20'd4096,
   parameter [19:0] LIMIT1 = 20'd16384,
   parameter [19:0] LIMIT2 = 20'd65536,
   parameter [19:0] LIMIT3 = 20'd262144
) (
   input wire clk_sys,
   input wire rst_n,
   input wire tick,
   input wire clear,
   input wire [1:0] periodSel,
   output reg overflow
);

   reg [CNT_W-1:0] count_reg;
   reg [CNT_W-1:0] limit;

   always @*
   begin
      case (periodSel)
         2'b00: limit = LIMIT0[CNT_W-1:0];
         2'b01: limit = LIMIT1[CNT_W-1:0];
         2'b10: limit = LIMIT2[CNT_W-1:0];
         default: limit = LIMIT3[CNT_W-1:0];
      endcase
   end

   // ----------------------------------------------------------------------
   // counting
   // ----------------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= {CNT_W{1'b0}};
         overflow <= 1'b0;
      end
      else
      begin
         overflow <= 1'b0;
         if (clear)
         begin
            count_reg <= {CNT_W{1'b0}};
         end
         else if (tick && (count_reg >= limit - {{(CNT_W-1){1'b0}}, 1'b1}))
         begin
            count_reg <= {CNT_W{1'b0}};
            overflow <= 1'b1;
         end
         else if (tick)
         begin
            count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // watchdog_period_timer

/* sim/free_running_watchdog_checker.sv */
// free_running_watchdog_checker.sv: port-level assertions for the watchdog unit
// assumes binding onto free_running_watchdog; sees its ports only
`timescale 1ns/1ps
`include "watchdog_defs.vh"
module free_running_watchdog_checker (
   input wire clk_sys,
   input wire rst_n,
   input wire lowSpeedClock,
   input wire lowSpeedClockRunning,
   input wire stopMode,
   input wire [15:0] sfrAddr,
   input wire sfrWrite,
   input wire sfrRead,
   input wire [7:0] sfrWrData,
   input wire [7:0] sfrRdData,
   input wire watchdogNmiRequest,
   input wire haltWake,
   input wire watchdogReset
);
   reg nmiSeen;
   reg runSeen;
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nmiSeen <= 1'b0;
         runSeen <= 1'b0;
      end
      else
      begin
         nmiSeen <= nmiSeen | watchdogNmiRequest;
         runSeen <= runSeen | lowSpeedClockRunning;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   nmi_one_cycle_a: assert property (watchdogNmiRequest |=> !watchdogNmiRequest)
      else $error("nmi request held too long");
   reset_one_cycle_a: assert property (watchdogReset |=> !watchdogReset)
      else $error("watchdog reset held too long");
   reset_after_nmi_a: assert property (watchdogReset |-> nmiSeen)
      else $error("watchdog reset without earlier nmi");
   events_apart_a: assert property (!(watchdogNmiRequest && watchdogReset))
      else $error("nmi and reset together");
   wake_tied_a: assert property (haltWake == watchdogNmiRequest)
      else $error("halt wake not with nmi");
   read_idle_a: assert property (!$past(sfrRead) |-> sfrRdData == 8'h00)
      else $error("read data outside read answer");
   pointer_only_a: assert property ($past(sfrRead) && $past(sfrAddr) == `ADDR_CLEAR_KEY
      |-> sfrRdData[7:1] == 7'h00) else $error("key read upper bits set");
   write_locked_a: assert property ($past(sfrRead) && $past(sfrAddr) == `ADDR_CLEAR_KEY
      && !$past(runSeen) |-> sfrRdData == 8'h00) else $error("pointer moved while locked");
   clean_release_a: assert property ($rose(rst_n)
      |-> !watchdogNmiRequest && !watchdogReset && sfrRdData == 8'h00)
      else $error("outputs busy after reset");
   cover property (watchdogNmiRequest);
   cover property (watchdogReset);
   cover property ($past(sfrRead) && sfrRdData[0]);
endmodule // free_running_watchdog_checker

/* sim/low_speed_source.sv */
// low_speed_source.sv: model of the low-speed oscillator feeding the watchdog
// assumes the bench raises startOsc once oscillation should begin
`timescale 1ns/1ps
module low_speed_source (
   input wire clk_sys,
   input wire rst_n,
   input wire startOsc,
   output reg lowSpeedClock,
   output reg lowSpeedClockRunning
);
   reg [1:0] divCnt;
   // still until started, then one rising edge per four cycles
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divCnt <= 2'h0;
         lowSpeedClock <= 1'b0;
         lowSpeedClockRunning <= 1'b0;
      end
      else
      begin
         lowSpeedClockRunning <= startOsc;
         divCnt <= lowSpeedClockRunning ? divCnt + 2'h1 : 2'h0;
         lowSpeedClock <= divCnt[1];
      end
   end
endmodule // low_speed_source

/* sim/free_running_watchdog_bench.sv */
// free_running_watchdog_bench.sv: self-checking bench for the watchdog unit
// assumes LS_HZ of 64, so code 00 overflows after 8 ticks of 4 cycles
`timescale 1ns/1ps
`include "watchdog_defs.vh"
module free_running_watchdog_bench;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg startOsc = 1'b0;
   reg stopMode = 1'b0;
   reg [15:0] sfrAddr = 16'h0000;
   reg sfrWrite = 1'b0;
   reg sfrRead = 1'b0;
   reg [7:0] sfrWrData = 8'h00;
   reg readLag = 1'b0;
   reg [7:0] rnd;
   wire lowSpeedClock, lowSpeedClockRunning, watchdogNmiRequest, haltWake, watchdogReset;
   wire [7:0] sfrRdData;
   logic [7:0] expQ[$];
   integer seed = 32'h950ee5ff;
   integer error_cnt = 0;
   integer check_count = 0;
   integer nmiCount = 0;
   integer resetCount = 0;
   integer cycleCnt = 0;
   integer i;
   always #5 clk_sys = ~clk_sys;
   low_speed_source i_osc (.clk_sys(clk_sys), .rst_n(rst_n), .startOsc(startOsc),
      .lowSpeedClock(lowSpeedClock), .lowSpeedClockRunning(lowSpeedClockRunning));
   free_running_watchdog #(.LARGE_VARIANT(0), .LS_HZ(64)) i_dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .lowSpeedClock(lowSpeedClock), .lowSpeedClockRunning(lowSpeedClockRunning),
      .stopMode(stopMode), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
      .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .watchdogNmiRequest(watchdogNmiRequest),
      .haltWake(haltWake), .watchdogReset(watchdogReset));
   task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input [15:0] a, input [7:0] d);
      @(posedge clk_sys);
      sfrWrite <= 1'b1;
      sfrAddr <= a;
      sfrWrData <= d;
      @(posedge clk_sys);
      sfrWrite <= 1'b0;
   endtask
   task rd(input [15:0] a, input [7:0] e);
      @(posedge clk_sys);
      sfrRead <= 1'b1;
      sfrAddr <= a;
      expQ.push_back(e);
      @(posedge clk_sys);
      sfrRead <= 1'b0;
   endtask
   // overflow lands 8 ticks after restart, within a tick of phase and two of latency
   task wait_event(input integer which);
      i = 0;
      while ((which ? resetCount : nmiCount) == 0 && i < 80)
      begin
         @(posedge clk_sys);
         i = i + 1;
      end
      check((i > 27 && i < 41) ? 8'h01 : 8'h00, 8'h01, "overflow delay");
   endtask
   // ----------------------------------------------------------------------
   // result monitor and hang guard
   // ----------------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      readLag <= sfrRead;
      cycleCnt <= cycleCnt + 1;
      nmiCount <= nmiCount + (watchdogNmiRequest === 1'b1);
      resetCount <= resetCount + (watchdogReset === 1'b1);
      if (cycleCnt == 3000)
      begin
         error_cnt = error_cnt + 1;
         tally_and_finish;
      end
   end
   always @(negedge clk_sys)
      if (readLag)
         check(sfrRdData, expQ.pop_front(), "read data");
   initial
   begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(`ADDR_CLEAR_KEY, `RESET_CLEAR_KEY);
      rd(`ADDR_PERIOD_SELECT, `RESET_PERIOD_SELECT);
      rd(16'h1234, 8'h00);
      wr(`ADDR_CLEAR_KEY, `KEY_FIRST);
      rd(`ADDR_CLEAR_KEY, 8'h00);
      startOsc <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // first key written, pointer read back, then a random key other than 0A5H
      wr(`ADDR_CLEAR_KEY, `KEY_FIRST);
      rd(`ADDR_CLEAR_KEY, 8'h01);
      rnd = 8'($random(seed));
      if (rnd == `KEY_SECOND)
         rnd = 8'h3c;
      wr(`ADDR_CLEAR_KEY, rnd);
      rd(`ADDR_CLEAR_KEY, 8'h00);
      @(posedge clk_sys);
      stopMode <= 1'b1;
      wr(`ADDR_CLEAR_KEY, `KEY_FIRST);
      rd(`ADDR_CLEAR_KEY, 8'h00);
      stopMode <= 1'b0;
      repeat (2) @(posedge clk_sys);
      wr(`ADDR_CLEAR_KEY, `KEY_FIRST);
      wr(`ADDR_CLEAR_KEY, `KEY_SECOND);
      for (i = 3; i >= 0; i = i - 1)
      begin
         rnd = 8'($random(seed));
         rnd[1:0] = i[1:0];
         wr(`ADDR_PERIOD_SELECT, rnd);
         rd(`ADDR_PERIOD_SELECT, rnd);
      end
      repeat (12)
      begin
         wr(`ADDR_CLEAR_KEY, `KEY_FIRST);
         wr(`ADDR_CLEAR_KEY, `KEY_SECOND);
      end
      check(8'(nmiCount), 8'h00, "nmi while cleared");
      wr(`ADDR_CLEAR_KEY, `KEY_FIRST);
      // first key again at pointer one: toggles only, must not clear
      wr(`ADDR_CLEAR_KEY, `KEY_FIRST);
      wait_event(0);
      rd(`ADDR_CLEAR_KEY, 8'h00);
      wait_event(1);
      check(8'(nmiCount), 8'h01, "nmi count");
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(`ADDR_PERIOD_SELECT, `RESET_PERIOD_SELECT);
      // let the monitor take the last read answer before the verdict
      repeat (2) @(posedge clk_sys);
      check(8'(expQ.size()), 8'h00, "reads left unanswered");
      tally_and_finish;
   end
endmodule // free_running_watchdog_bench
bind free_running_watchdog free_running_watchdog_checker i_chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .lowSpeedClock(lowSpeedClock), .lowSpeedClockRunning(lowSpeedClockRunning),
   .stopMode(stopMode), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
   .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .watchdogNmiRequest(watchdogNmiRequest),
   .haltWake(haltWake), .watchdogReset(watchdogReset));
